// ---- mfi_top.sv ----
// multi-function interrupt source registers with AHB-Lite access
// assumes source events and service acknowledges are pulses on hclk
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`default_nettype none

module mfi_top #(
    parameter int ADDR_W = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hce,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic standard_timer_match_a,
    input wire logic standard_timer_match_p,
    input wire logic compact_timer_match_a,
    input wire logic compact_timer_match_p,
    input wire logic periodic_timer_match_a,
    input wire logic periodic_timer_match_p,
    input wire logic eeprom_op_done,
    input wire logic low_voltage_detected,
    input wire logic [mfi_pkg::MF_NUM-1:0] irq_service_ack,
    output logic [mfi_pkg::MF_NUM-1:0] mf_irq_request,
    output logic global_irq_enable,
    output logic irq
);
    import mfi_pkg::*;

    mfi_reg_if rif ();

    logic [7:0] std_val;
    logic [7:0] cp_val;
    logic [7:0] ee_val;
    logic [MF_NUM-1:0] mf_rise;
    logic [MF_NUM-1:0] mf_flag_q;
    logic [MF_NUM-1:0] mf_en_q;
    logic global_en_q;
    logic [MF_NUM-1:0] stat_q;
    logic [MF_NUM-1:0] mask_q;
    logic wr_std;
    logic wr_cp;
    logic wr_ee;
    logic wr_ctrl;
    logic wr_glob;
    logic wr_mask;
    logic rd_stat;

    // ****************************************
    // bus slave
    // ****************************************
    mfi_ahb_slave #(.ADDR_W(ADDR_W)) u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .hce(hce),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .regs(rif.slave)
    );

    assign wr_std = rif.wr_en && (rif.idx == IDX_STD_TIMER);
    assign wr_cp = rif.wr_en && (rif.idx == IDX_CMP_PER_TIMER);
    assign wr_ee = rif.wr_en && (rif.idx == IDX_EEPROM_LOWVOLT);
    assign wr_ctrl = rif.wr_en && (rif.idx == IDX_MF_CTRL);
    assign wr_glob = rif.wr_en && (rif.idx == IDX_GLOBAL);
    assign wr_mask = rif.wr_en && (rif.idx == IDX_IRQ_MASK);
    assign rd_stat = rif.rd_en && (rif.idx == IDX_IRQ_STATUS);

    // ****************************************
    // source registers, one per multi-function interrupt
    // ****************************************
    // register 0, 1, 2 feed multi-function interrupts 0, 1, 2
    mfi_src_reg #(.NSRC(STD_NSRC)) u_std (
        .hclk(hclk),
        .hresetn(hresetn),
        .hce(hce),
        .evt({standard_timer_match_a, standard_timer_match_p}),
        .wr(wr_std),
        .wdata(rif.wdata),
        .value(std_val),
        .rise(mf_rise[0])
    );

    mfi_src_reg #(.NSRC(CMP_PER_NSRC)) u_cp (
        .hclk(hclk),
        .hresetn(hresetn),
        .hce(hce),
        .evt({compact_timer_match_a, compact_timer_match_p, periodic_timer_match_a, periodic_timer_match_p}),
        .wr(wr_cp),
        .wdata(rif.wdata),
        .value(cp_val),
        .rise(mf_rise[1])
    );

    mfi_src_reg #(.NSRC(EE_LV_NSRC)) u_ee (
        .hclk(hclk),
        .hresetn(hresetn),
        .hce(hce),
        .evt({eeprom_op_done, low_voltage_detected}),
        .wr(wr_ee),
        .wdata(rif.wdata),
        .value(ee_val),
        .rise(mf_rise[2])
    );

    // ****************************************
    // multi-function flags and enables
    // ****************************************
    for (genvar n = 0; n < MF_NUM; n++) begin : g_mf
        // a new source request beats a simultaneous service or software clear
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                mf_flag_q[n] <= MF_RESET[n];
            end else if (hce) begin
                if (mf_rise[n]) begin
                    mf_flag_q[n] <= 1'b1;
                end else if (irq_service_ack[n]) begin
                    mf_flag_q[n] <= 1'b0;
                end else if (wr_ctrl) begin
                    mf_flag_q[n] <= rif.wdata[MF_FLAG_LSB+n];
                end
            end
        end

        // sticky status for the interrupt line; a read clears, a new event wins
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                stat_q[n] <= 1'b0;
            end else if (hce) begin
                if (mf_rise[n]) begin
                    stat_q[n] <= 1'b1;
                end else if (rd_stat) begin
                    stat_q[n] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mf_en_q <= MF_RESET;
        end else if (hce && wr_ctrl) begin
            mf_en_q <= rif.wdata[MF_EN_LSB +: MF_NUM];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_q <= MF_RESET;
        end else if (hce && wr_mask) begin
            mask_q <= rif.wdata[MF_NUM-1:0];
        end
    end

    // servicing drops the global enable to stop nesting; software may set it again
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            global_en_q <= GLOBAL_EN_RESET;
        end else if (hce) begin
            if (|irq_service_ack) begin
                global_en_q <= 1'b0;
            end else if (wr_glob) begin
                global_en_q <= rif.wdata[GLOBAL_EN_BIT];
            end
        end
    end

    // ****************************************
    // outputs and read-back
    // ****************************************
    // source flags are not touched by a service; software must clear them
    assign mf_irq_request = mf_flag_q & mf_en_q & {MF_NUM{global_en_q}};
    assign global_irq_enable = global_en_q;
    assign irq = |(stat_q & mask_q);

    always_comb begin
        rif.rdata = 8'h00;
        unique case (rif.idx)
            IDX_STD_TIMER: rif.rdata = std_val;
            IDX_CMP_PER_TIMER: rif.rdata = cp_val;
            IDX_EEPROM_LOWVOLT: rif.rdata = ee_val;
            IDX_MF_CTRL: begin
                rif.rdata[MF_FLAG_LSB +: MF_NUM] = mf_flag_q;
                rif.rdata[MF_EN_LSB +: MF_NUM] = mf_en_q;
            end
            IDX_GLOBAL: rif.rdata[GLOBAL_EN_BIT] = global_en_q;
            IDX_IRQ_STATUS: rif.rdata[MF_NUM-1:0] = stat_q;
            IDX_IRQ_MASK: rif.rdata[MF_NUM-1:0] = mask_q;
            default: rif.rdata = 8'h00;
        endcase
    end

endmodule

`default_nettype wire

// ---- mfi_pkg.sv ----
// constants shared by the multi-function interrupt source register block
// assumes a single 100 MHz clock and an AHB-Lite master with word-only access
`default_nettype none

package mfi_pkg;

    // ****************************************
    // register map (word indices from haddr[4:2], one word each)
    // ****************************************
    localparam int IDX_W = 3;
    localparam logic [IDX_W-1:0] IDX_STD_TIMER = 3'h0;
    localparam logic [IDX_W-1:0] IDX_CMP_PER_TIMER = 3'h1;
    localparam logic [IDX_W-1:0] IDX_EEPROM_LOWVOLT = 3'h2;
    localparam logic [IDX_W-1:0] IDX_MF_CTRL = 3'h3;
    localparam logic [IDX_W-1:0] IDX_GLOBAL = 3'h4;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 3'h5;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 3'h6;
    localparam logic [IDX_W-1:0] IDX_LAST = IDX_IRQ_MASK;

    // ****************************************
    // field layout
    // ****************************************
    localparam int FLAG_LSB = 4;
    localparam int MF_NUM = 3;
    localparam int MF_FLAG_LSB = 0;
    localparam int MF_EN_LSB = 4;
    localparam int GLOBAL_EN_BIT = 0;
    localparam int STD_NSRC = 2;
    localparam int CMP_PER_NSRC = 4;
    localparam int EE_LV_NSRC = 2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] SRC_RESET = 8'h00;
    localparam logic [MF_NUM-1:0] MF_RESET = 3'h0;
    localparam logic GLOBAL_EN_RESET = 1'b0;

endpackage

`default_nettype wire

// ---- mfi_reg_if.sv ----
// register access strobes between the bus slave and the register file
// assumes both sides run on the same clock
`default_nettype none

interface mfi_reg_if;
    import mfi_pkg::*;
    logic wr_en;
    logic rd_en;
    logic [IDX_W-1:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport slave (output wr_en, output rd_en, output idx, output wdata, input rdata);
    modport regs (input wr_en, input rd_en, input idx, input wdata, output rdata);
endinterface

`default_nettype wire

// ---- mfi_src_reg.sv ----
// one 8-bit interrupt source register: flags in bits 4 and up, enables from bit 0
// assumes event inputs are one-cycle pulses from logic on the same clock
`default_nettype none

module mfi_src_reg #(
    parameter int NSRC = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hce,
    input wire logic [NSRC-1:0] evt,
    input wire logic wr,
    input wire logic [7:0] wdata,
    output logic [7:0] value,
    output logic rise
);
    import mfi_pkg::*;

    logic [NSRC-1:0] flag_q;
    logic [NSRC-1:0] en_q;
    logic [NSRC-1:0] gated_prev_q;
    logic [NSRC-1:0] gated;

    // flags and enables share one byte, so at most four sources fit
    if (NSRC < 1 || NSRC > FLAG_LSB) begin : g_bad_nsrc
        $error("mfi_src_reg: NSRC must be 1..4");
    end

    // ****************************************
    // per-source flag and enable
    // ****************************************
    for (genvar k = 0; k < NSRC; k++) begin : g_src
        // a pulse coinciding with a software clear still lands
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                flag_q[k] <= 1'b0;
            end else if (hce) begin
                if (evt[k]) begin
                    flag_q[k] <= 1'b1;
                end else if (wr) begin
                    flag_q[k] <= wdata[FLAG_LSB+k];
                end
            end
        end

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                en_q[k] <= 1'b0;
            end else if (hce && wr) begin
                en_q[k] <= wdata[k];
            end
        end
    end

    assign gated = flag_q & en_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gated_prev_q <= '0;
        end else if (hce) begin
            gated_prev_q <= gated;
        end
    end

    // new enabled request, so one service does not re-trigger on a flag left standing
    assign rise = |(gated & ~gated_prev_q);

    always_comb begin
        value = SRC_RESET;
        value[FLAG_LSB +: NSRC] = flag_q;
        value[NSRC-1:0] = en_q;
    end

endmodule

`default_nettype wire

// ---- mfi_ahb_slave.sv ----
// AHB-Lite slave front end for the source register block
// assumes one slave on the bus, word-only single transfers; response always OKAY
`default_nettype none

module mfi_ahb_slave #(
    parameter int ADDR_W = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hce,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    mfi_reg_if.slave regs
);
    import mfi_pkg::*;

    logic take;
    logic hit;
    logic wr_pend_q;
    logic rd_pend_q;
    logic hit_q;
    logic [IDX_W-1:0] idx_q;
    logic [7:0] rdata_q;

    // the decoder reads address bits 4..0 and checks the rest for zero
    if (ADDR_W < 5) begin : g_bad_addr_w
        $error("mfi_ahb_slave: ADDR_W must be at least 5");
    end

    // ****************************************
    // address phase
    // ****************************************
    assign take = hce && hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
    assign hit = (haddr[ADDR_W-1:5] == '0) && (haddr[1:0] == 2'h0) && (haddr[4:2] <= IDX_LAST);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
        end else if (hce) begin
            wr_pend_q <= take && hwrite;
            rd_pend_q <= take && !hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hit_q <= 1'b0;
            idx_q <= '0;
        end else if (take) begin
            hit_q <= hit;
            idx_q <= haddr[4:2];
        end
    end

    // ****************************************
    // data phase
    // ****************************************
    // reads take one wait state so a write just before is already visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 8'h00;
        end else if (hce && rd_pend_q) begin
            rdata_q <= hit_q ? regs.rdata : 8'h00;
        end
    end

    assign regs.wr_en = hce && wr_pend_q && hit_q;
    assign regs.rd_en = hce && rd_pend_q && hit_q;
    assign regs.idx = idx_q;
    assign regs.wdata = hwdata[7:0];
    assign hreadyout = !rd_pend_q;
    assign hresp = 1'b0;
    assign hrdata = {24'h000000, rdata_q};

endmodule

`default_nettype wire

// ---- mfi_evt_model.sv ----
// far-side model: event sources and the cpu interrupt logic
// assumes the bench requests events on fire, one cycle each
`default_nettype none

module mfi_evt_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [7:0] fire,
    input wire logic svc_en,
    input wire logic [2:0] mf_irq_request,
    output logic [7:0] evt,
    output logic [2:0] ack
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // registered pulses, lowest pending request serviced first
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt <= 8'h00;
            ack <= 3'h0;
        end else begin
            evt <= fire;
            // one service per request: no second pulse while the first is still on the line
            ack <= (svc_en && ack == 3'h0) ? (mf_irq_request & (~mf_irq_request + 3'h1)) : 3'h0;
        end
    end
endmodule

`default_nettype wire

// ---- mfi_top_props.sv ----
// checker for the source register block, bound to its top module
// assumes a single slave whose hreadyout is fed back as hready
`default_nettype none

module mfi_top_props #(
    parameter int ADDR_W = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hce,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [2:0] irq_service_ack,
    input wire logic [2:0] mf_irq_request,
    input wire logic global_irq_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // helpers and properties
    // ****************************************
    logic take;
    logic [ADDR_W-1:0] rd_addr_q;
    assign take = hce && hsel && hready && htrans[1] && (hsize == 3'h2);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_addr_q <= '0;
        end else if (take && !hwrite) begin
            rd_addr_q <= haddr;
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
    upper_zero_a: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
    read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
    write_nowait_a: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
    single_wait_a: assert property (!hreadyout |=> hreadyout) else $error("wait too long");
    rsvd_zero_a: assert property ($rose(hreadyout) && (rd_addr_q == 'h0 || rd_addr_q == 'h8)
        |-> hrdata[7:6] == 2'b00 && hrdata[3:2] == 2'b00) else $error("unimplemented bits read high");
    req_needs_gie_a: assert property (|mf_irq_request |-> global_irq_enable) else $error("request without enable");
    ack_gie_a: assert property (hce && |irq_service_ack |=> !global_irq_enable) else $error("enable kept");
    ack_req_a: assert property (hce && |irq_service_ack |=> mf_irq_request == 3'h0) else $error("request kept");
    cover property (take && !hwrite);
    cover property (|irq_service_ack);
    cover property ($rose(|mf_irq_request));
endmodule

`default_nettype wire

// ---- multifunction_irq_source_regs_test.sv ----
// self-checking bench with a behavioural register model
// assumes the event model drives the source pulses and the acknowledge
`default_nettype none

module multifunction_irq_source_regs_test;
    import mfi_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [7:0] fire = 8'h00;
    logic svc_en = 1'b0;
    logic hreadyout, hresp, global_irq_enable, irq;
    logic [31:0] hrdata;
    logic [7:0] evt;
    logic [2:0] ack, mf_irq_request;
    int errors = 0, num_checks = 0, seed = 97;
    int src[3], gp[3], mf, mfen, gie, st, msk, en, r;
    int ereg[8] = '{0, 0, 1, 1, 1, 1, 2, 2};
    int ebit[8] = '{5, 4, 7, 6, 5, 4, 5, 4};

    always #5 hclk = ~hclk;

    mfi_top dut_u (.hclk(hclk), .hresetn(hresetn), .hce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .standard_timer_match_a(evt[0]), .standard_timer_match_p(evt[1]),
        .compact_timer_match_a(evt[2]), .compact_timer_match_p(evt[3]), .periodic_timer_match_a(evt[4]),
        .periodic_timer_match_p(evt[5]), .eeprom_op_done(evt[6]), .low_voltage_detected(evt[7]),
        .irq_service_ack(ack), .mf_irq_request(mf_irq_request), .global_irq_enable(global_irq_enable), .irq(irq));
    mfi_evt_model part_u (.hclk(hclk), .hresetn(hresetn), .fire(fire), .svc_en(svc_en),
        .mf_irq_request(mf_irq_request), .evt(evt), .ack(ack));

    // ****************************************
    // model, bus and checks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    function automatic void upd();
        int g;
        for (int i = 0; i < 3; i++) begin
            g = (src[i] >> 4) & src[i] & 15;
            if ((g & ~gp[i]) != 0) begin
                mf |= 1 << i;
                st |= 1 << i;
            end
            gp[i] = g;
        end
    endfunction

    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] rd_v);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_v = hrdata;
    endtask

    task automatic wr(input int a, input int d);
        logic [31:0] v;
        bus(32'(a), 1'b1, 32'(d), v);
        if (a == 0) src[0] = d & 8'h33;
        else if (a == 4) src[1] = d & 8'hff;
        else if (a == 8) src[2] = d & 8'h33;
        else if (a == 12) begin
            mf = d & 7;
            mfen = (d >> 4) & 7;
        end else if (a == 16) gie = d & 1;
        else if (a == 24) msk = d & 7;
        upd();
        repeat (2) @(posedge hclk);
    endtask

    task automatic rd(input int a);
        logic [31:0] v;
        int e;
        bus(32'(a), 1'b0, 32'h0, v);
        e = a == 0 ? src[0] : a == 4 ? src[1] : a == 8 ? src[2] : a == 12 ? (mf | mfen << 4) :
            a == 16 ? gie : a == 20 ? st : a == 24 ? msk : 0;
        if (a == 20) st = 0;
        chk("hrdata", 32'(e), v);
    endtask

    task automatic outs();
        chk("mf_irq_request", 32'(mf & mfen & (gie ? 7 : 0)), {29'h0, mf_irq_request});
        chk("irq", 32'((st & msk) != 0), {31'h0, irq});
        chk("global_irq_enable", 32'(gie), {31'h0, global_irq_enable});
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        stop_test();
    end

    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        outs();
        for (int a = 0; a <= 32; a += 4) rd(a);
        wr(24, 7);
        wr(12, 8'h70);
        wr(16, 1);
        for (int i = 0; i < 3; i++) begin
            wr(i * 4, $random(seed));
            rd(i * 4);
            outs();
        end
        rd(12);
        rd(20);
        for (int i = 0; i < 3; i++) wr(i * 4, 0);
        wr(12, 8'h70);
        for (int e = 0; e < 8; e++) begin
            en = $random(seed) & 1;
            r = ereg[e] * 4;
            wr(24, $random(seed) & 7);
            wr(r, en << (ebit[e] - 4));
            fire[e] <= 1'b1;
            @(posedge hclk);
            fire <= 8'h00;
            repeat (4) @(posedge hclk);
            src[ereg[e]] |= 1 << ebit[e];
            upd();
            outs();
            rd(r);
            rd(20);
            outs();
            svc_en <= 1'b1;
            repeat (4) @(posedge hclk);
            svc_en <= 1'b0;
            if (en) begin
                mf &= ~(1 << ereg[e]);
                gie = 0;
            end
            @(posedge hclk);
            outs();
            rd(r);
            wr(r, 0);
            rd(r);
            wr(16, 1);
        end
        stop_test();
    end
endmodule

bind mfi_top mfi_top_props #(.ADDR_W(ADDR_W)) props_u (.hclk(hclk), .hresetn(hresetn), .hce(hce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq_service_ack(irq_service_ack), .mf_irq_request(mf_irq_request),
    .global_irq_enable(global_irq_enable));

`default_nettype wire
